/* File: ccb_pkg.sv */
`default_nettype none
package ccb_pkg;

  // ----------------------------------------------------------------
  // page layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned CAL_FIRST      = 56;   // first calibration byte
  localparam int unsigned CAL_BYTES      = 36;   // bytes 56..91
  localparam int unsigned RSVD_FIRST     = 92;   // reserved 92..94
  localparam int unsigned RSVD_LAST      = 94;
  localparam logic [7:0]  CHECKSUM_ADDR  = 8'h5F;

  // register offsets (byte addresses on the page)
  localparam logic [7:0] RX_POWER_COEFF_ORDER4_OFS  = 8'h38;
  localparam logic [7:0] RX_POWER_COEFF_ORDER3_OFS  = 8'h3C;
  localparam logic [7:0] RX_POWER_COEFF_ORDER2_OFS  = 8'h40;
  localparam logic [7:0] RX_POWER_COEFF_ORDER1_OFS  = 8'h44;
  localparam logic [7:0] RX_POWER_COEFF_ORDER0_OFS  = 8'h48;
  localparam logic [7:0] BIAS_CURRENT_SLOPE_OFS     = 8'h4C;
  localparam logic [7:0] BIAS_CURRENT_OFFSET_OFS    = 8'h4E;
  localparam logic [7:0] TX_OUTPUT_POWER_SLOPE_OFS  = 8'h50;
  localparam logic [7:0] TX_OUTPUT_POWER_OFFSET_OFS = 8'h52;
  localparam logic [7:0] TEMPERATURE_SLOPE_OFS      = 8'h54;
  localparam logic [7:0] TEMPERATURE_OFFSET_OFS     = 8'h56;
  localparam logic [7:0] SUPPLY_VOLTAGE_SLOPE_OFS   = 8'h58;
  localparam logic [7:0] SUPPLY_VOLTAGE_OFFSET_OFS  = 8'h5A;
  localparam logic [7:0] RESERVED_GAP_OFS           = 8'h5C;

  // ----------------------------------------------------------------
  // field layout of a float coefficient
  // ----------------------------------------------------------------
  localparam int unsigned FLOAT_SIGN_BIT  = 31;
  localparam int unsigned FLOAT_EXP_MSB   = 30;
  localparam int unsigned FLOAT_EXP_LSB   = 23;
  localparam int unsigned FLOAT_MANT_MSB  = 22;

  // ----------------------------------------------------------------
  // reset values: internally calibrated device
  // ----------------------------------------------------------------
  localparam logic [31:0] FLOAT_ZERO   = 32'h0000_0000;
  localparam logic [31:0] FLOAT_ONE    = 32'h3F80_0000;  // sign 0, exp 127, mant 0
  localparam logic [15:0] SLOPE_ONE    = 16'h0100;       // 8.8 fixed point 1.0
  localparam logic [15:0] OFFSET_ZERO  = 16'h0000;
  localparam logic [7:0]  RSVD_VALUE   = 8'h00;

  // whole image, byte 56 in the top bits, each value MSB first
  localparam logic [CAL_BYTES*8-1:0] CAL_RESET_IMAGE = {
    FLOAT_ZERO, FLOAT_ZERO, FLOAT_ZERO, FLOAT_ONE, FLOAT_ZERO,
    SLOPE_ONE, OFFSET_ZERO, SLOPE_ONE, OFFSET_ZERO,
    SLOPE_ONE, OFFSET_ZERO, SLOPE_ONE, OFFSET_ZERO};

endpackage
`default_nettype wire

/* File: ccb_calibration_bank.sv */
// Function
// - each receive-power coefficient is four bytes at rising addresses, MSB in bit 7 of the lowest.
// - internally calibrated, order 1 coefficient reads 1.0 and orders 0, 2, 3, 4 read zero.
// - each slope is unsigned 8.8 fixed point, integer byte above, fraction in 1/256 steps.
// - every two-byte slope and offset is stored MSB first, bit 7 of the lower address on top.
// - internally calibrated, the four slopes read 1.0.
// - each offset is 16-bit two's complement in the unit of its measurement.
// - internally calibrated, the four offsets read zero.
// - the checksum byte is the low eight bits of the sum of page bytes 0 to 94.
// - a float coefficient is sign in bit 31, exponent in 30..23, mantissa in 22..0.
`timescale 1ns/100ps
`default_nettype none

module ccb_calibration_bank #(
  parameter logic [ccb_pkg::CAL_BYTES*8-1:0] RESET_IMAGE = ccb_pkg::CAL_RESET_IMAGE
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output var  logic [7:0] rd_data,
  output var  logic       rd_valid,
  output var  logic       rd_hit,
  input  wire logic       prog_en,
  input  wire logic [7:0] prog_addr,
  input  wire logic [7:0] prog_data,
  input  wire logic [7:0] lower_page_sum,
  output var  logic [7:0] checksum
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam logic [7:0] CAL_LO   = 8'(ccb_pkg::CAL_FIRST);
  localparam logic [7:0] CAL_HI   = 8'(ccb_pkg::CAL_FIRST + ccb_pkg::CAL_BYTES - 1);
  localparam logic [7:0] RSVD_LO  = 8'(ccb_pkg::RSVD_FIRST);
  localparam logic [7:0] RSVD_HI  = 8'(ccb_pkg::RSVD_LAST);

  logic [7:0] cal_mem_reg [ccb_pkg::CAL_BYTES];
  logic [7:0] checksum_reg;
  logic [7:0] checksum_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       rd_valid_reg;
  logic       rd_hit_reg;

  wire        rd_in_cal;
  wire        rd_in_rsvd;
  wire        rd_is_sum;
  wire        rd_mapped;
  wire        prog_in_cal;
  wire [7:0]  rd_index;
  wire [7:0]  prog_index;

  // windows of the page that this bank answers for
  assign rd_in_cal   = (rd_addr >= CAL_LO) && (rd_addr <= CAL_HI);
  assign rd_in_rsvd  = (rd_addr >= RSVD_LO) && (rd_addr <= RSVD_HI);
  assign rd_is_sum   = (rd_addr == ccb_pkg::CHECKSUM_ADDR);
  assign rd_mapped   = rd_in_cal || rd_in_rsvd || rd_is_sum;
  assign prog_in_cal = (prog_addr >= CAL_LO) && (prog_addr <= CAL_HI);
  assign rd_index    = rd_addr - CAL_LO;
  assign prog_index  = prog_addr - CAL_LO;

  // ----------------------------------------------------------------
  // calibration storage
  // ----------------------------------------------------------------
  // reset loads the internally calibrated image; byte 0 of the array is
  // page byte 56 and holds the top byte of the order 4 coefficient
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ccb_pkg::CAL_BYTES; i++) begin
        cal_mem_reg[i] <= RESET_IMAGE[ccb_pkg::CAL_BYTES*8-1-8*i -: 8];
      end
    end else if (clk_en && prog_en && prog_in_cal) begin
      // factory writes only; reserved and checksum bytes are not writable
      cal_mem_reg[prog_index[5:0]] <= prog_data;
    end
  end

  // ----------------------------------------------------------------
  // checksum
  // ----------------------------------------------------------------
  // bytes 0..55 come in pre-summed from the threshold table; reserved
  // bytes are zero so they add nothing. kept in hardware so a factory
  // rewrite can never leave a stale checksum behind
  always_comb begin
    checksum_next = lower_page_sum;
    for (int i = 0; i < ccb_pkg::CAL_BYTES; i++) begin
      checksum_next = 8'(checksum_next + cal_mem_reg[i]);
    end
    checksum_next = 8'(checksum_next + 3 * ccb_pkg::RSVD_VALUE);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      checksum_reg <= 8'h00;
    end else if (clk_en) begin
      checksum_reg <= checksum_next;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // byte lanes leave exactly as stored, so floats keep sign and exponent
  // in the first two bytes and fixed-point values keep integer byte first
  always_comb begin
    rd_data_next = 8'h00;
    if (rd_in_cal) begin
      rd_data_next = cal_mem_reg[rd_index[5:0]];
    end else if (rd_in_rsvd) begin
      rd_data_next = ccb_pkg::RSVD_VALUE;
    end else if (rd_is_sum) begin
      rd_data_next = checksum_reg;
    end
  end

  // one-cycle read latency; unmapped addresses answer zero with hit low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
      rd_hit_reg   <= 1'b0;
    end else if (clk_en) begin
      rd_valid_reg <= rd_en;
      if (rd_en) begin
        rd_data_reg <= rd_data_next;
        rd_hit_reg  <= rd_mapped;
      end
    end
  end

  assign rd_data  = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_hit   = rd_hit_reg;
  assign checksum = checksum_reg;

endmodule
`default_nettype wire

/* File: ccb_host.sv */
`timescale 1ns/100ps
`default_nettype none
module ccb_host (
  input  wire logic       core_clk,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output var  logic       rd_en,
  output var  logic [7:0] rd_addr
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 8'hFF;
  end
  // host side check of a float coefficient: all-ones exponent with a
  // nonzero mantissa is not a number and must be treated as invalid
  function automatic logic is_nan(input logic [31:0] f);
    return (f[30:23] == 8'hFF) && (f[22:0] != 23'h0);
  endfunction
  // host side conversion of a raw reading with 8.8 slope and signed offset
  function automatic logic [15:0] convert(input logic [15:0] slope,
                                          input logic [15:0] offset,
                                          input logic [15:0] raw);
    logic [31:0] p;
    p = slope * raw;
    return 16'(p[23:8] + offset);
  endfunction
  // single byte read, answer taken in the cycle after the request edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;  // released lines never keep the old address
    #1 d = (rd_valid === 1'b1) ? rd_data : 'x;
  endtask
endmodule
`default_nettype wire

/* File: ccb_calibration_bank_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ccb_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       rd_hit,
  input wire logic       prog_en,
  input wire logic [7:0] prog_addr,
  input wire logic [7:0] prog_data,
  input wire logic [7:0] lower_page_sum,
  input wire logic [7:0] checksum
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // read decode seen from the host side
  wire logic go = clk_en && rd_en;
  wire logic map = rd_addr >= 8'h38 && rd_addr <= 8'h5F;
  wire logic pw = clk_en && prog_en && prog_addr >= 8'h38 && prog_addr <= 8'h5B;
  a_read_valid: assert property (go |=> rd_valid)
    else $error("read not answered");
  a_read_quiet: assert property (clk_en && !rd_en |=> !rd_valid && $stable(rd_data))
    else $error("answer without request");
  a_unmapped_zero: assert property (go && !map |=> rd_data == 8'h00 && !rd_hit)
    else $error("unmapped read not zero");
  a_mapped_hit: assert property (go && map |=> rd_hit)
    else $error("mapped read missed");
  a_reserved_zero: assert property (go && rd_addr inside {[8'h5C:8'h5E]} |=> rd_data == 8'h00)
    else $error("reserved byte not zero");
  a_byte_stored: assert property (pw ##1 (go && rd_addr == $past(prog_addr))
    |=> rd_data == $past(prog_data, 2))
    else $error("stored byte lost");
  a_sum_steady: assert property ((!prog_en && $stable(lower_page_sum)) [*2] |=> $stable(checksum))
    else $error("checksum drifted");
  a_hit_holds: assert property (clk_en && !rd_en |=> $stable(rd_hit))
    else $error("hit flag moved");
endmodule
bind ccb_calibration_bank ccb_chk i_ccb_chk (.core_clk, .rst_n, .clk_en, .rd_en, .rd_addr,
  .rd_data, .rd_valid, .rd_hit, .prog_en, .prog_addr, .prog_data, .lower_page_sum, .checksum);
`default_nettype wire

/* File: calibration_constant_bank_test.sv */
`timescale 1ns/100ps
`default_nettype none
module calibration_constant_bank_test;
  logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, prog_en = 1'b0, rd_en, rd_valid, rd_hit;
  logic [7:0] prog_addr = 8'h00, prog_data = 8'h00, lower_page_sum = 8'h00;
  logic [7:0] rd_addr, rd_data, checksum, v, a, mem [56:95];
  logic [31:0] rnd = 32'hE5FD;
  logic [63:0] w;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #12.5 core_clk = ~core_clk;
  ccb_calibration_bank i_ccb_calibration_bank (.core_clk, .rst_n, .clk_en, .rd_en, .rd_addr,
    .rd_data, .rd_valid, .rd_hit, .prog_en, .prog_addr, .prog_data, .lower_page_sum, .checksum);
  ccb_host i_ccb_host (.core_clk, .rd_valid, .rd_data, .rd_en, .rd_addr);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected byte: unmapped and reserved read zero, byte 95 is the page sum
  function automatic logic [7:0] exp_rd(input int ad);
    logic [7:0] s;
    s = lower_page_sum;
    for (int i = 56; i < 95; i++) s += mem[i];
    if (ad == 95) return s;
    return (ad < 56 || ad > 95) ? 8'h00 : mem[ad];
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("fails %0d of %0d checks", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write request, dropped at the edge where the caller's read is raised
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    prog_en <= 1'b1;
    prog_addr <= ad;
    prog_data <= d;
    if (ad >= 56 && ad <= 91) mem[ad] = d;
    fork
      begin
        @(posedge core_clk);
        prog_en <= 1'b0;
        prog_addr <= ~ad;
      end
    join_none
  endtask
  task automatic rd_chk(input logic [7:0] ad);
    i_ccb_host.rd(ad, v);
    chk(v, exp_rd(ad));
    chk(rd_hit, ad >= 56 && ad <= 95);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    rnd = lfsr(rnd);
    lower_page_sum = rnd[7:0];
    // internal-cal image: order1 float 1.0, slopes 1.0, all else zero
    for (int i = 56; i < 96; i++) mem[i] = (i == 68) ? 8'h3F : (i == 69) ? 8'h80 :
      (i inside {76, 80, 84, 88}) ? 8'h01 : 8'h00;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 256; i++) rd_chk(i[7:0]);
    // order 1 coefficient as a host sees it, then a unity conversion
    for (int i = 0; i < 4; i++) begin
      i_ccb_host.rd(8'(68 + i), v);
      w[31 - 8 * i -: 8] = v;
    end
    chk(i_ccb_host.is_nan(w[31:0]), 1'b0);
    chk(i_ccb_host.convert({mem[76], mem[77]}, {mem[78], mem[79]}, 16'h1234), 16'h1234);
    // a write while the clock enable is low must leave the byte alone
    @(posedge core_clk);
    clk_en <= 1'b0;
    prog_en <= 1'b1;
    prog_addr <= 8'd60;
    prog_data <= 8'hA5;
    @(posedge core_clk);
    clk_en <= 1'b1;
    prog_en <= 1'b0;
    prog_addr <= 8'h00;
    rd_chk(8'd60);
    // float -1.5, slope 255+255/256, offset -32768 at bytes 72..79
    for (int i = 0; i < 8; i++) begin
      w = 64'hBFC0_0000_FFFF_8000;
      wr(8'(72 + i), w[63 - 8 * i -: 8]);
      rd_chk(8'(72 + i));
    end
    for (int i = 0; i < 8; i++) begin
      i_ccb_host.rd(8'(72 + i), v);
      w[63 - 8 * i -: 8] = v;
    end
    chk(w, 64'hBFC0_0000_FFFF_8000);
    repeat (60) begin
      rnd = lfsr(rnd);
      a = rnd[8] ? rnd[7:0] : 8'(56 + rnd[15:10] % 36);
      wr(a, rnd[23:16]);
      rd_chk(a);
      rd_chk(8'h5F);
    end
    chk(checksum, exp_rd(95));
    give_verdict;
  end
endmodule
`default_nettype wire
